// [boot_mode_select_cfg.svh]
// Constants for the boot-mode selection block
`ifndef BOOT_MODE_SELECT_CFG_SVH
`define BOOT_MODE_SELECT_CFG_SVH
`define BOOT_ROM_START 24'hFF_0000
`define BOOT_CODE_W 3
`define BOOT_CODE_RESET 3'h0
`define BOOT_CODE_MIN 3'h1
`define BOOT_CODE_MAX 3'h5
`define BOOT_VEC_HOLD 2'h2
`endif

// [boot_mode_select_pkg.sv]
// Types for the boot-mode selection block
package boot_mode_select_pkg;
  typedef enum logic [2:0] {
    BOOT_RESERVED0 = 3'h0,
    BOOT_EMI_LOAD8 = 3'h1,
    BOOT_XIP8 = 3'h2,
    BOOT_XIP16 = 3'h3,
    BOOT_SPI_SMALL = 3'h4,
    BOOT_SPI_LARGE = 3'h5,
    BOOT_RESERVED6 = 3'h6,
    BOOT_RESERVED7 = 3'h7
  } boot_mode_t;
  typedef enum logic [1:0] {
    SEQ_RESET = 2'h0,
    SEQ_WAIT_BUS = 2'h1,
    SEQ_VECTOR = 2'h2,
    SEQ_RUN = 2'h3
  } boot_seq_t;
endpackage

// [boot_pin_sync.sv]
// Two-stage synchroniser for the boot-select pins
`timescale 1ns/10ps
`default_nettype none
module boot_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Pins
  input wire logic [2:0] pinIn,
  output logic [2:0] pinSync
);
  logic [2:0] stage1;
  logic [2:0] stage2;
  logic [2:0] next_stage1;
  logic [2:0] next_stage2;
  always_comb begin
    next_stage1 = clkEn ? pinIn : stage1;
    next_stage2 = clkEn ? stage1 : stage2;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= 3'h0;
      stage2 <= 3'h0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end
  assign pinSync = stage2;
endmodule
`default_nettype wire

// [boot_mode_select.sv]
// Boot-mode capture, decode and boot interrupt vectoring
// Operation
// R1 - The select pins are captured once at hardware reset and only the captured code is used.
// R2 - The boot interrupt cannot be masked and vectors to the boot ROM start.
// R3 - The boot interrupt is raised after a hardware reset and after a software reset.
// R4 - After either reset fetch starts at the boot ROM start whatever the select code.
// R5 - The code is decoded into eight modes of which only 1 to 5 are valid.
// R6 - Code 1 loads from external byte-wide memory over the external memory interface.
// R7 - Code 2 executes in place from external byte-wide memory.
// R8 - Code 3 executes in place from external 16-bit memory.
// R9 - Code 4 boots from a small SPI memory and code 5 from a large one.
// R10 - On reset release the jump to the boot ROM waits for no pending bus request.
// R11 - The latched code stays stable until the next hardware reset and is readable.
`timescale 1ns/10ps
`default_nettype none
`include "boot_mode_select_cfg.svh"
module boot_mode_select
  import boot_mode_select_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Boot select pins
  input wire logic boot_select_bit2,
  input wire logic boot_select_bit1,
  input wire logic boot_select_bit0,
  // Core side
  input wire logic softReset,
  input wire logic busRequest,
  input wire logic intMask,
  // Results
  output logic bootIrq,
  output logic fetchLoad,
  output logic [23:0] fetchAddr,
  output logic [2:0] bootCode,
  output logic modeValid,
  output logic useExternalMemoryInterface,
  output logic executeInPlace,
  output logic wide16,
  output logic spiBoot,
  output logic spiLarge
);
  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  logic [2:0] pinSync;
  boot_pin_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .pinIn({boot_select_bit2, boot_select_bit1, boot_select_bit0}),
    .pinSync(pinSync)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic codeIsValid(input logic [2:0] code);
    codeIsValid = (code >= `BOOT_CODE_MIN) && (code <= `BOOT_CODE_MAX);
  endfunction

  // ---------------------------------------------------------------
  // Capture and boot sequence
  // ---------------------------------------------------------------
  // Sync needs two edges after release before the pins are trusted
  logic [1:0] settle;
  logic captured;
  logic [2:0] code;
  boot_seq_t seq;
  logic [1:0] next_settle;
  logic next_captured;
  logic [2:0] next_code;
  boot_seq_t next_seq;
  logic next_irq;
  logic next_load;
  logic [23:0] next_addr;

  always_comb begin
    next_settle = settle;
    next_captured = captured;
    next_code = code;
    next_seq = seq;
    next_irq = bootIrq;
    next_load = fetchLoad;
    next_addr = fetchAddr;
    if (clkEn) begin
      // Pulses last one enabled cycle and are held while frozen
      next_irq = 1'b0;
      next_load = 1'b0;
      if (!captured) begin
        if (settle == `BOOT_VEC_HOLD) begin
          next_code = pinSync; // R1
          next_captured = 1'b1; // R11
        end else begin
          next_settle = settle + 2'h1;
        end
      end
      unique case (seq)
        SEQ_RESET: begin
          if (captured) begin
            next_seq = SEQ_WAIT_BUS;
          end
        end
        SEQ_WAIT_BUS: begin
          if (!busRequest) begin // R10
            next_seq = SEQ_VECTOR;
          end
        end
        SEQ_VECTOR: begin
          // Mask ignored: boot interrupt is nonmaskable
          next_irq = 1'b1; // R2 R3
          next_load = 1'b1;
          next_addr = `BOOT_ROM_START; // R4
          next_seq = SEQ_RUN;
        end
        SEQ_RUN: begin
          // Software reset keeps the code: only the pin reset samples again
          if (softReset) begin // R3
            next_seq = SEQ_WAIT_BUS;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle <= 2'h0;
      captured <= 1'b0;
      code <= `BOOT_CODE_RESET;
      seq <= SEQ_RESET;
      bootIrq <= 1'b0;
      fetchLoad <= 1'b0;
      fetchAddr <= `BOOT_ROM_START;
    end else begin
      settle <= next_settle;
      captured <= next_captured;
      code <= next_code;
      seq <= next_seq;
      bootIrq <= next_irq;
      fetchLoad <= next_load;
      fetchAddr <= next_addr;
    end
  end

  // ---------------------------------------------------------------
  // Mode outputs
  // ---------------------------------------------------------------
  boot_mode_t mode;
  assign mode = boot_mode_t'(code);
  assign bootCode = code; // R11
  assign modeValid = captured && codeIsValid(code); // R5
  assign useExternalMemoryInterface = modeValid && (mode == BOOT_EMI_LOAD8); // R6
  assign executeInPlace = modeValid && (mode == BOOT_XIP8 || mode == BOOT_XIP16); // R7 R8
  assign wide16 = modeValid && (mode == BOOT_XIP16); // R8
  assign spiBoot = modeValid && (mode == BOOT_SPI_SMALL || mode == BOOT_SPI_LARGE); // R9
  assign spiLarge = modeValid && (mode == BOOT_SPI_LARGE); // R9

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_code_held: assert property (@(posedge clk) disable iff (!arst_n) // R11
    $past(captured) |-> $stable(code))
    else $error("boot code changed");
  a_freeze_hold: assert property (@(posedge clk) disable iff (!arst_n) // R11
    !clkEn |=> $stable(code) && $stable(seq) && $stable(bootIrq))
    else $error("state moved while frozen");
  a_no_capture: assert property (@(posedge clk) disable iff (!arst_n) // R1
    !captured |-> bootCode == 3'h0 && !modeValid)
    else $error("code before capture");
  a_capture_val: assert property (@(posedge clk) disable iff (!arst_n) // R1
    (!captured && settle == 2'h2 && clkEn) |=> code == $past(pinSync))
    else $error("capture wrong");

  a_irq_addr: assert property (@(posedge clk) disable iff (!arst_n) // R4
    bootIrq |-> fetchAddr == 24'hFF_0000 && fetchLoad)
    else $error("bad vector");
  a_irq_nomask: assert property (@(posedge clk) disable iff (!arst_n) // R2
    (seq == SEQ_VECTOR && clkEn) |=> bootIrq)
    else $error("irq missing");
  a_mask_ignored: assert property (@(posedge clk) disable iff (!arst_n) // R2
    (seq == SEQ_VECTOR && clkEn && intMask) |=> bootIrq && fetchLoad)
    else $error("boot irq masked");
  a_one_pulse: assert property (@(posedge clk) disable iff (!arst_n) // R3
    (bootIrq && clkEn) |=> !bootIrq && !fetchLoad)
    else $error("boot pulse too long");
  a_bus_wait: assert property (@(posedge clk) disable iff (!arst_n) // R10
    (seq == SEQ_WAIT_BUS && busRequest) |=> seq == SEQ_WAIT_BUS && !bootIrq)
    else $error("early vector");
  a_soft_rst: assert property (@(posedge clk) disable iff (!arst_n) // R3
    (seq == SEQ_RUN && softReset && clkEn && !busRequest) ##1 (clkEn && !busRequest) ##1 clkEn
    |=> bootIrq)
    else $error("no soft boot");

  a_valid_dec: assert property (@(posedge clk) disable iff (!arst_n) // R5
    modeValid |-> (code != 3'h0 && code < 3'h6))
    else $error("bad valid");
  a_one_mode: assert property (@(posedge clk) disable iff (!arst_n) // R6
    modeValid |-> $onehot({useExternalMemoryInterface, executeInPlace, spiBoot}))
    else $error("mode overlap");
  a_ext_code: assert property (@(posedge clk) disable iff (!arst_n) // R6
    useExternalMemoryInterface |-> code == 3'h1)
    else $error("external load code");
  a_xip_byte: assert property (@(posedge clk) disable iff (!arst_n) // R7
    (executeInPlace && !wide16) |-> code == 3'h2)
    else $error("byte execute code");
  a_xip_wide: assert property (@(posedge clk) disable iff (!arst_n) // R8
    wide16 |-> executeInPlace && code == 3'h3)
    else $error("wide execute code");
  a_spi_large: assert property (@(posedge clk) disable iff (!arst_n) // R9
    spiLarge |-> spiBoot && code == 3'h5)
    else $error("spi size");
  a_spi_small: assert property (@(posedge clk) disable iff (!arst_n) // R9
    (spiBoot && !spiLarge) |-> code == 3'h4)
    else $error("small spi code");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  c_hw_boot: cover property (@(posedge clk) disable iff (!arst_n) bootIrq && !$past(captured, 4));
  c_soft_boot: cover property (@(posedge clk) disable iff (!arst_n) seq == SEQ_RUN && softReset);
  c_bus_stall: cover property (@(posedge clk) disable iff (!arst_n) seq == SEQ_WAIT_BUS && busRequest);
  c_spi: cover property (@(posedge clk) disable iff (!arst_n) spiLarge);
  c_illegal: cover property (@(posedge clk) disable iff (!arst_n) captured && !modeValid);
endmodule
`default_nettype wire

// [boot_bus_peer.sv]
// Bus requester model facing the boot block
`timescale 1ns/10ps
`default_nettype none
module boot_bus_peer (
  // Clock
  input wire logic clk,
  // Bench control
  input wire logic kick,
  input wire logic [3:0] holdCycles,
  // Request to the block
  output logic busRequest
);
  logic [3:0] left = 4'h0;
  // Request held a set span after each kick, to stall vectoring
  always @(negedge clk) begin
    if (kick)
      left = holdCycles;
    else if (left != 4'h0)
      left = left - 4'h1;
  end
  assign busRequest = (left != 4'h0);
endmodule
`default_nettype wire

// [boot_mode_select_tb.sv]
// Self-checking bench for the boot-mode selection block
`timescale 1ns/10ps
`default_nettype none
`define CHECK(n, e, s) begin comparisons++; if ((e) !== (s)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module boot_mode_select_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] pins = 3'h0;
  logic softReset = 1'b0;
  logic intMask = 1'b0;
  logic kick = 1'b0;
  logic clkEn = 1'b1;
  logic [3:0] hold = 4'h0;
  logic busRequest, bootIrq, fetchLoad, modeValid, ext, xip, wide16, spiBoot, spiLarge;
  logic [23:0] fetchAddr;
  logic [2:0] bootCode;
  int cyc = 0;
  int mismatches = 0;
  int comparisons = 0;
  logic [64:0] notes[$];
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  boot_bus_peer boot_bus_peer_inst (.clk(clk), .kick(kick), .holdCycles(hold),
    .busRequest(busRequest));
  boot_mode_select boot_mode_select_inst (.clk(clk), .arst_n(arst_n), .clkEn(clkEn),
    .boot_select_bit2(pins[2]), .boot_select_bit1(pins[1]), .boot_select_bit0(pins[0]),
    .softReset(softReset), .busRequest(busRequest), .intMask(intMask), .bootIrq(bootIrq),
    .fetchLoad(fetchLoad), .fetchAddr(fetchAddr), .bootCode(bootCode), .modeValid(modeValid),
    .useExternalMemoryInterface(ext), .executeInPlace(xip), .wide16(wide16),
    .spiBoot(spiBoot), .spiLarge(spiLarge));
  // ----------------------------------------
  // Expected outputs per code
  // ----------------------------------------
  function automatic logic [32:0] expv(input logic [2:0] c);
    logic v;
    v = (c >= 3'h1) && (c <= 3'h5);
    return {24'hFF_0000, c, v, v && c == 3'h1, v && c[2:1] == 2'h1, v && c == 3'h3,
      v && c[2], v && c == 3'h5};
  endfunction
  task automatic results;
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Extra cycles catch a boot pulse that lasts too long
  task automatic waitDone;
    repeat (40) if (notes.size() != 0) @(negedge clk);
    repeat (3) @(negedge clk);
    `CHECK("pending", 1'b0, notes.size() != 0)
  endtask
  task automatic hwBoot(input logic [2:0] code, input int len);
    int h;
    h = $urandom % 7;
    @(negedge clk);
    arst_n <= 1'b0;
    pins <= code;
    repeat (len) @(negedge clk);
    `CHECK("reset", {24'hFF_0000, 4'h0}, {fetchAddr, bootIrq, bootCode})
    hold <= h[3:0];
    notes.push_back({32'(cyc + (h + 2 > 5 ? h + 2 : 5) + 1), expv(code)});
    arst_n <= 1'b1;
    kick <= 1'b1;
    @(negedge clk);
    kick <= 1'b0;
    waitDone;
    pins <= 3'($urandom);
  endtask
  // Pins were scrambled, so the old code must survive
  task automatic swBoot(input logic [2:0] code);
    int h;
    h = $urandom % 7;
    // Frozen clock enable must swallow a software reset
    @(negedge clk);
    clkEn <= 1'b0;
    softReset <= 1'b1;
    repeat (3) @(negedge clk);
    `CHECK("frozen code", code, bootCode)
    clkEn <= 1'b1;
    softReset <= 1'b0;
    @(negedge clk);
    hold <= h[3:0];
    softReset <= 1'b1;
    kick <= 1'b1;
    intMask <= 1'b1;
    notes.push_back({32'(cyc + h + 3), expv(code)});
    @(negedge clk);
    softReset <= 1'b0;
    kick <= 1'b0;
    intMask <= 1'($urandom);
    waitDone;
  endtask
  always @(negedge clk) begin
    if (bootIrq === 1'b1) begin
      `CHECK("irq", 1'b1, notes.size() != 0)
      if (notes.size() != 0) begin
        `CHECK("cycle", notes[0][64:33], 32'(cyc))
        `CHECK("load", 1'b1, fetchLoad)
        `CHECK("outs", notes[0][32:0], {fetchAddr, bootCode, modeValid, ext, xip, wide16,
          spiBoot, spiLarge})
        void'(notes.pop_front());
      end
    end
  end
  initial begin
    void'($urandom(32'hbc272c24));
    hwBoot(3'h1, 20);
    for (int c = 0; c < 8; c++) begin
      hwBoot(3'(c), 2);
      swBoot(3'(c));
    end
    results;
  end
  initial begin
    #200_000;
    mismatches++;
    results;
  end
endmodule
`default_nettype wire
